// file: inc/pwlc_pkg.sv
// package: register map, field layout, reset values and timing for the clock/watchdog/low-power control block
// What this block does
// - power-off bit disables pll; cpu clock is oscillator through divider only.
// - off or bypass: divide by 4 for select 0/1, 2 for 2, 1 for 3.
// - after power-up or external reset the clock comes up in bypass.
// - ratio zero selects bypass; pll keeps running but is not used.
// - nonzero ratio n enables pll; locked clock is osc times n over divider.
// - every ratio write falls back to bypass until the pll reports lock.
// - on oscillator loss in enabled or bypass mode a limp clock keeps running.
// - in bypass, limp clock is switched in automatically once clock was seen.
// - watchdog counter freezes while the input clock is missing.
// - clock failure issues internal reset and sets readable missing-clock flag.
// - 8-bit up counter; at maximum drives 512-cycle low reset unless disabled.
// - key sequence 0x55 then 0xAA clears the watchdog counter.
// - in standby watchdog runs on oscillator and its interrupt can wake.
// - in idle watchdog interrupt reaches cpu via interrupt expander.
// - mode field: idle 00, standby 01, halt 1x; idle needs no action.
// - idle all clocks on; standby stops cpu clock, osc and pll keep running; halt stops osc, pll, watchdog.
// - idle exits on reset, watchdog interrupt, enabled interrupt or nonmaskable interrupt.
// - standby wake on selected port a lines qualified for programmed osc clocks.
// - halt wakes on external reset or selected port a line.
// - low-power entry or exit never changes output pin states.
// - ratio and status reset only on external or watchdog reset.
package pwlc_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] PWLC_PLL_STATUS_OFS = 8'h00;
  localparam logic [7:0] PWLC_PLL_RATIO_OFS = 8'h04;
  localparam logic [7:0] PWLC_LOW_POWER_OFS = 8'h08;
  localparam logic [7:0] PWLC_WAKE_SEL_OFS = 8'h0C;
  localparam logic [7:0] PWLC_WD_CTRL_OFS = 8'h10;
  localparam logic [7:0] PWLC_WD_KEY_OFS = 8'h14;
  localparam logic [7:0] PWLC_WD_COUNT_OFS = 8'h18;
  localparam logic [7:0] PWLC_SYS_STATUS_OFS = 8'h1C;
  // ==========================================
  // field positions
  localparam int PWLC_STS_LOCKED_BIT = 0;
  localparam int PWLC_STS_OFF_BIT = 3;
  localparam int PWLC_STS_CPU_CLOCK_IN_DIVIDE_SELECT_LSB = 7;
  localparam int PWLC_WDC_DISABLE_BIT = 6;
  localparam int PWLC_LPM_QUAL_LSB = 2;
  localparam int PWLC_LPM_WDWAKE_BIT = 15;
  localparam int PWLC_SYS_MCLK_BIT = 0;
  localparam int PWLC_SYS_WDFLAG_BIT = 1;
  localparam int PWLC_SYS_WDOUT_BIT = 2;
  // ==========================================
  // reset values and keys
  localparam logic [3:0] PWLC_RATIO_RESET = 4'h0;
  localparam logic [1:0] PWLC_CPU_CLOCK_IN_DIVIDE_SELECT_RESET = 2'h0;
  localparam logic [5:0] PWLC_QUAL_RESET = 6'h00;
  localparam logic [31:0] PWLC_WAKE_SEL_RESET = 32'h00000000;
  localparam logic [7:0] PWLC_WD_KEY1 = 8'h55;
  localparam logic [7:0] PWLC_WD_KEY2 = 8'hAA;
  localparam logic [7:0] PWLC_WD_MAX = 8'hFF;
  localparam logic [31:0] PWLC_BUS_UNMAPPED = 32'h00000000;
  // ==========================================
  // timing
  localparam int PWLC_WD_PULSE_CYCLES = 512;
  localparam int PWLC_PLL_SETTLE_CYCLES = 131072;
  localparam int PWLC_WD_PRESCALE = 512;
  localparam int PWLC_OSC_MISS_CYCLES = 16;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    PWLC_CLK_BYPASS,
    PWLC_CLK_LOCKING,
    PWLC_CLK_PLL,
    PWLC_CLK_OFF
  } pwlc_clk_mode_t;
  typedef enum logic [1:0] {
    PWLC_LP_RUN,
    PWLC_LP_IDLE,
    PWLC_LP_STANDBY,
    PWLC_LP_HALT
  } pwlc_lp_state_t;
  typedef struct packed {
    logic [3:0] ratio;
    logic [1:0] cpu_clock_in_divide_select;
    logic use_pll;
    logic use_limp;
    logic pll_powered;
  } pwlc_clk_sel_t;
endpackage

// file: hdl/pwlc_ctrl.sv
// clock select, watchdog and low-power sequencer with a wishbone register port
`timescale 1ns/1ps
module pwlc_ctrl #(
  parameter int PLL_LOCK_CYCLES = pwlc_pkg::PWLC_PLL_SETTLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_reset_n_i,
  input wire logic osc_clock_tick_i,
  input wire logic [31:0] port_a_i,
  input wire logic enabled_int_i,
  input wire logic ext_nonmaskable_int_i,
  input wire logic idle_request_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output pwlc_pkg::pwlc_clk_sel_t clk_sel_o,
  output logic cpu_clock_en_o,
  output logic osc_run_o,
  output logic watchdog_reset_pulse_n_o,
  output logic watchdog_wake_int_o,
  output logic missing_clock_reset_o,
  output logic wake_o,
  output logic [1:0] lp_state_o
);
  // ==========================================
  // registers
  logic [3:0] ratio_reg;
  logic [1:0] cpu_clock_in_divide_select_reg;
  logic pll_off_reg;
  logic [1:0] lpm_mode_reg;
  logic [5:0] qual_reg;
  logic wd_wake_en_reg;
  logic [31:0] wake_sel_reg;
  logic wd_disable_reg;
  logic wd_flag_reg;
  logic [7:0] wd_count_reg;
  logic [9:0] wd_pre_reg;
  logic key_armed_reg;
  logic [9:0] wd_pulse_reg;
  logic mclk_flag_reg;
  logic seen_osc_reg;
  logic [4:0] miss_cnt_reg;
  logic [17:0] lock_cnt_reg;
  logic mrst_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [5:0] qual_cnt_reg;
  pwlc_pkg::pwlc_clk_mode_t clk_mode_reg;
  pwlc_pkg::pwlc_lp_state_t lp_reg;
  pwlc_pkg::pwlc_lp_state_t lp_next;
  pwlc_pkg::pwlc_clk_mode_t clk_mode_next;

  // ==========================================
  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  // writes land on the edge where the master sees ack high
  wire wr = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];
  wire wr_sts = wr && (wb_adr_i == pwlc_pkg::PWLC_PLL_STATUS_OFS);
  wire wr_ratio = wr && (wb_adr_i == pwlc_pkg::PWLC_PLL_RATIO_OFS);
  wire wr_lpm = wr && (wb_adr_i == pwlc_pkg::PWLC_LOW_POWER_OFS);
  wire wr_wsel = wr && (wb_adr_i == pwlc_pkg::PWLC_WAKE_SEL_OFS);
  wire wr_wdc = wr && (wb_adr_i == pwlc_pkg::PWLC_WD_CTRL_OFS);
  wire wr_key = wr && (wb_adr_i == pwlc_pkg::PWLC_WD_KEY_OFS);
  wire wr_sys = wr && (wb_adr_i == pwlc_pkg::PWLC_SYS_STATUS_OFS);

  // ==========================================
  // clock supervision
  wire osc_missing = seen_osc_reg && (miss_cnt_reg == 5'(pwlc_pkg::PWLC_OSC_MISS_CYCLES));
  wire osc_ok = osc_clock_tick_i && !osc_missing;
  wire locked = (clk_mode_reg == pwlc_pkg::PWLC_CLK_PLL);
  wire ext_rst = rst_i || !external_reset_n_i;
  wire wd_pre_end = (wd_pre_reg == 10'(pwlc_pkg::PWLC_WD_PRESCALE - 1));
  wire wd_fire = !wd_disable_reg && (wd_count_reg == pwlc_pkg::PWLC_WD_MAX) && wd_pre_end;
  // ratio and status cleared only by external or watchdog reset
  wire pll_rst = ext_rst || wd_fire;
  wire halted = (lp_reg == pwlc_pkg::PWLC_LP_HALT);
  // watchdog only advances on a real oscillator tick, not on limp clock or in halt
  wire wd_tick = osc_ok && !halted && !wd_disable_reg;

  always_comb begin
    clk_mode_next = clk_mode_reg;
    case (clk_mode_reg)
      pwlc_pkg::PWLC_CLK_BYPASS: if (ratio_reg != 4'h0) clk_mode_next = pwlc_pkg::PWLC_CLK_LOCKING;
      pwlc_pkg::PWLC_CLK_LOCKING: if (lock_cnt_reg == 18'(PLL_LOCK_CYCLES - 1)) clk_mode_next = pwlc_pkg::PWLC_CLK_PLL;
      pwlc_pkg::PWLC_CLK_PLL: clk_mode_next = pwlc_pkg::PWLC_CLK_PLL;
      pwlc_pkg::PWLC_CLK_OFF: if (!pll_off_reg) clk_mode_next = pwlc_pkg::PWLC_CLK_BYPASS;
      default: clk_mode_next = pwlc_pkg::PWLC_CLK_BYPASS;
    endcase
    if (wr_ratio) begin
      clk_mode_next = pwlc_pkg::PWLC_CLK_BYPASS;
    end
    if (pll_off_reg) begin
      clk_mode_next = pwlc_pkg::PWLC_CLK_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (pll_rst) begin
      ratio_reg <= pwlc_pkg::PWLC_RATIO_RESET;
      cpu_clock_in_divide_select_reg <= pwlc_pkg::PWLC_CPU_CLOCK_IN_DIVIDE_SELECT_RESET;
      pll_off_reg <= 1'b0;
      clk_mode_reg <= pwlc_pkg::PWLC_CLK_BYPASS;
      lock_cnt_reg <= 18'h00000;
    end else begin
      if (wr_ratio) begin
        ratio_reg <= wb_dat_i[3:0];
      end
      if (wr_sts) begin
        pll_off_reg <= wb_dat_i[pwlc_pkg::PWLC_STS_OFF_BIT];
        cpu_clock_in_divide_select_reg <= wb_dat_i[pwlc_pkg::PWLC_STS_CPU_CLOCK_IN_DIVIDE_SELECT_LSB +: 2];
      end
      clk_mode_reg <= clk_mode_next;
      if (clk_mode_reg == pwlc_pkg::PWLC_CLK_LOCKING && !wr_ratio) begin
        lock_cnt_reg <= lock_cnt_reg + 18'h00001;
      end else begin
        lock_cnt_reg <= 18'h00000;
      end
    end
  end

  // oscillator watch: missing once seen and silent for too long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_osc_reg <= 1'b0;
      miss_cnt_reg <= 5'h00;
      mrst_reg <= 1'b0;
    end else begin
      if (osc_clock_tick_i) begin
        seen_osc_reg <= 1'b1;
        miss_cnt_reg <= 5'h00;
      end else if (seen_osc_reg && !osc_missing && !halted) begin
        miss_cnt_reg <= miss_cnt_reg + 5'h01;
      end
      mrst_reg <= osc_missing && !mclk_flag_reg;
    end
  end

  // ==========================================
  // watchdog
  always_ff @(posedge clk_i) begin
    if (ext_rst) begin
      wd_count_reg <= 8'h00;
      wd_pre_reg <= 10'h000;
      key_armed_reg <= 1'b0;
      wd_pulse_reg <= 10'h000;
      wd_disable_reg <= 1'b0;
      wd_flag_reg <= 1'b0;
    end else begin
      if (wr_wdc) begin
        wd_disable_reg <= wb_dat_i[pwlc_pkg::PWLC_WDC_DISABLE_BIT];
      end
      if (wr_key) begin
        key_armed_reg <= (wb_dat_i[7:0] == pwlc_pkg::PWLC_WD_KEY1);
      end
      if (wr_key && key_armed_reg && wb_dat_i[7:0] == pwlc_pkg::PWLC_WD_KEY2) begin
        wd_count_reg <= 8'h00;
        wd_pre_reg <= 10'h000;
      end else if (wd_tick) begin
        wd_pre_reg <= wd_pre_end ? 10'h000 : wd_pre_reg + 10'h001;
        if (wd_pre_end) begin
          wd_count_reg <= wd_count_reg + 8'h01;
        end
      end
      if (wd_fire && wd_tick) begin
        wd_pulse_reg <= 10'(pwlc_pkg::PWLC_WD_PULSE_CYCLES);
        wd_flag_reg <= 1'b1;
      end else begin
        if (wd_pulse_reg != 10'h000 && osc_ok) begin
          wd_pulse_reg <= wd_pulse_reg - 10'h001;
        end
        if (wr_sys && wb_dat_i[pwlc_pkg::PWLC_SYS_WDFLAG_BIT]) begin
          wd_flag_reg <= 1'b0;
        end
      end
    end
  end

  // missing clock flag survives its own reset
  always_ff @(posedge clk_i) begin
    if (ext_rst) begin
      mclk_flag_reg <= 1'b0;
    end else if (osc_missing) begin
      mclk_flag_reg <= 1'b1;
    end else if (wr_sys && wb_dat_i[pwlc_pkg::PWLC_SYS_MCLK_BIT]) begin
      mclk_flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // low-power sequencer
  wire [31:0] wake_lines = ~port_a_i & wake_sel_reg;
  wire wake_low = |wake_lines;
  wire qualified = wake_low && (qual_cnt_reg >= qual_reg);
  wire wd_int = wd_flag_reg;

  always_comb begin
    lp_next = lp_reg;
    case (lp_reg)
      pwlc_pkg::PWLC_LP_RUN: begin
        if (idle_request_i) begin
          case (lpm_mode_reg)
            2'b00: lp_next = pwlc_pkg::PWLC_LP_IDLE;
            2'b01: lp_next = pwlc_pkg::PWLC_LP_STANDBY;
            default: lp_next = pwlc_pkg::PWLC_LP_HALT;
          endcase
        end
      end
      pwlc_pkg::PWLC_LP_IDLE: begin
        if (wd_int || enabled_int_i || ext_nonmaskable_int_i) lp_next = pwlc_pkg::PWLC_LP_RUN;
      end
      pwlc_pkg::PWLC_LP_STANDBY: begin
        if ((wd_int && wd_wake_en_reg) || qualified || ext_nonmaskable_int_i) lp_next = pwlc_pkg::PWLC_LP_RUN;
      end
      pwlc_pkg::PWLC_LP_HALT: begin
        if (wake_low || ext_nonmaskable_int_i) lp_next = pwlc_pkg::PWLC_LP_RUN;
      end
      default: lp_next = pwlc_pkg::PWLC_LP_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (ext_rst) begin
      lp_reg <= pwlc_pkg::PWLC_LP_RUN;
      qual_cnt_reg <= 6'h00;
      lpm_mode_reg <= 2'b00;
      qual_reg <= pwlc_pkg::PWLC_QUAL_RESET;
      wd_wake_en_reg <= 1'b0;
      wake_sel_reg <= pwlc_pkg::PWLC_WAKE_SEL_RESET;
    end else begin
      lp_reg <= lp_next;
      if (wr_lpm) begin
        lpm_mode_reg <= wb_dat_i[1:0];
        qual_reg <= wb_dat_i[pwlc_pkg::PWLC_LPM_QUAL_LSB +: 6];
        wd_wake_en_reg <= wb_dat_i[pwlc_pkg::PWLC_LPM_WDWAKE_BIT];
      end
      if (wr_wsel) begin
        wake_sel_reg <= wb_dat_i;
      end
      if (!wake_low || lp_reg != pwlc_pkg::PWLC_LP_STANDBY) begin
        qual_cnt_reg <= 6'h00;
      end else if (osc_ok && !qualified) begin
        qual_cnt_reg <= qual_cnt_reg + 6'h01;
      end
    end
  end

  // ==========================================
  // register read
  wire [31:0] sts_word = {23'h0, cpu_clock_in_divide_select_reg, 3'h0, pll_off_reg, 2'h0, locked};
  wire [31:0] lpm_word = {16'h0, wd_wake_en_reg, 7'h0, qual_reg, lpm_mode_reg};
  wire [31:0] sys_word = {29'h0, !watchdog_reset_pulse_n_o, wd_flag_reg, mclk_flag_reg};
  wire [31:0] rd_mux =
    (wb_adr_i == pwlc_pkg::PWLC_PLL_STATUS_OFS) ? sts_word :
    (wb_adr_i == pwlc_pkg::PWLC_PLL_RATIO_OFS) ? {28'h0, ratio_reg} :
    (wb_adr_i == pwlc_pkg::PWLC_LOW_POWER_OFS) ? lpm_word :
    (wb_adr_i == pwlc_pkg::PWLC_WAKE_SEL_OFS) ? wake_sel_reg :
    (wb_adr_i == pwlc_pkg::PWLC_WD_CTRL_OFS) ? {25'h0, wd_disable_reg, 6'h0} :
    (wb_adr_i == pwlc_pkg::PWLC_WD_COUNT_OFS) ? {24'h0, wd_count_reg} :
    (wb_adr_i == pwlc_pkg::PWLC_SYS_STATUS_OFS) ? sys_word :
    pwlc_pkg::PWLC_BUS_UNMAPPED;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      rdata_reg <= rd_mux;
    end
  end

  // ==========================================
  // outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign clk_sel_o.ratio = ratio_reg;
  assign clk_sel_o.cpu_clock_in_divide_select = cpu_clock_in_divide_select_reg;
  assign clk_sel_o.use_pll = locked;
  assign clk_sel_o.use_limp = osc_missing && !pll_off_reg;
  assign clk_sel_o.pll_powered = !pll_off_reg && !halted;
  // output pins are untouched: only clock enables change
  assign cpu_clock_en_o = (lp_reg == pwlc_pkg::PWLC_LP_RUN) || (lp_reg == pwlc_pkg::PWLC_LP_IDLE);
  assign osc_run_o = !halted;
  assign watchdog_reset_pulse_n_o = (wd_pulse_reg == 10'h000);
  assign watchdog_wake_int_o = wd_int;
  assign missing_clock_reset_o = mrst_reg;
  assign wake_o = (lp_reg != pwlc_pkg::PWLC_LP_RUN) && (lp_next == pwlc_pkg::PWLC_LP_RUN);
  assign lp_state_o = lp_reg;
endmodule

// file: tb/pwlc_ctrl_assertions.sv
// checker: port-level relations of the clock, watchdog and low-power block
`timescale 1ns/1ps
module pwlc_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire pwlc_pkg::pwlc_clk_sel_t clk_sel_o,
  input wire logic cpu_clock_en_o,
  input wire logic osc_run_o,
  input wire logic missing_clock_reset_o,
  input wire logic wake_o,
  input wire logic [1:0] lp_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // clock selection, missing-clock reset and wake to run
  a_reset_bypass: assert property ($fell(rst_i) |-> clk_sel_o.ratio == 4'h0 && !clk_sel_o.use_pll)
    else $error("no bypass after reset");
  a_ratio_zero_bypass: assert property (clk_sel_o.ratio == 4'h0 |-> !clk_sel_o.use_pll)
    else $error("pll used with zero ratio");
  a_pll_needs_ratio: assert property (clk_sel_o.use_pll |-> clk_sel_o.ratio != 4'h0 && clk_sel_o.pll_powered)
    else $error("pll used without ratio or power");
  a_off_no_pll: assert property (!clk_sel_o.pll_powered |-> !clk_sel_o.use_pll && !clk_sel_o.use_limp)
    else $error("pll path used while powered off");
  a_ratio_write_fallback: assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o &&
    wb_adr_i == pwlc_pkg::PWLC_PLL_RATIO_OFS |-> ##[0:1] !clk_sel_o.use_pll [*2])
    else $error("no bypass after ratio write");
  a_limp_on_loss: assert property (missing_clock_reset_o && clk_sel_o.pll_powered |-> ##[0:2] clk_sel_o.use_limp)
    else $error("limp clock not selected on loss");
  a_mclk_one_pulse: assert property (missing_clock_reset_o |=> !missing_clock_reset_o)
    else $error("missing clock reset longer than one cycle");
  a_wake_to_run: assert property (wake_o |=> lp_state_o == 2'h0)
    else $error("wake without return to run");
  // ==========================================
  // low-power clocks
  a_halt_clocks_off: assert property (lp_state_o == 2'h3 |-> !osc_run_o && !cpu_clock_en_o)
    else $error("clocks running in halt");
  a_standby_osc_only: assert property (lp_state_o == 2'h2 |-> osc_run_o && !cpu_clock_en_o)
    else $error("wrong clocks in standby");
  a_idle_clocks_on: assert property (lp_state_o == 2'h1 |-> osc_run_o && cpu_clock_en_o)
    else $error("clocks stopped in idle");
endmodule

// file: tb/pwlc_osc_model.sv
// partner: oscillator, reset pin and pulled-up wake pins
`timescale 1ns/1ps
module pwlc_osc_model (
  input wire logic clk_i,
  input wire logic osc_enable_i,
  input wire logic osc_run_i,
  input wire logic [31:0] pull_low_i,
  input wire logic pin_reset_i,
  output logic osc_clock_tick_o,
  output logic [31:0] port_a_o,
  output logic external_reset_n_o
);
  initial osc_clock_tick_o = 1'b0;
  // oscillator stops when removed or halted
  always @(posedge clk_i) osc_clock_tick_o <= osc_enable_i && osc_run_i;
  // wake pins idle high, asserted low
  assign port_a_o = ~pull_low_i;
  // reset pin low while asserted
  assign external_reset_n_o = !pin_reset_i;
endmodule

// file: tb/tb_pwlc_ctrl.sv
// testbench: register, clock, watchdog and low-power scenarios
`timescale 1ns/1ps
module tb_pwlc_ctrl;
  logic clk_i = 1'b0, rst_i = 1'b1, osc_en = 1'b1, idle_req = 1'b0, en_int = 1'b0, nmi = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, pin_rst = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h00000000, pull_low = 32'h00000000, rd, cnt;
  logic osc_tick, ext_rst_n, wb_ack, cpu_en, osc_run, wd_n, wd_int, mclk, wake;
  logic [31:0] port_a, wb_q;
  logic [1:0] lp;
  pwlc_pkg::pwlc_clk_sel_t sel;
  int failures = 0, comparisons = 0, cycles = 0, wakes = 0;
  localparam int LIMIT = 20000;
  pwlc_osc_model u_osc (.clk_i(clk_i), .osc_enable_i(osc_en), .osc_run_i(osc_run), .pull_low_i(pull_low),
    .pin_reset_i(pin_rst), .osc_clock_tick_o(osc_tick), .port_a_o(port_a), .external_reset_n_o(ext_rst_n));
  pwlc_ctrl #(.PLL_LOCK_CYCLES(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .external_reset_n_i(ext_rst_n),
    .osc_clock_tick_i(osc_tick), .port_a_i(port_a), .enabled_int_i(en_int), .ext_nonmaskable_int_i(nmi),
    .idle_request_i(idle_req), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .clk_sel_o(sel),
    .cpu_clock_en_o(cpu_en), .osc_run_o(osc_run), .watchdog_reset_pulse_n_o(wd_n),
    .watchdog_wake_int_o(wd_int), .missing_clock_reset_o(mclk), .wake_o(wake), .lp_state_o(lp));
  // ==========================================
  // clock, timeout and helpers
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    wb_sel <= 4'hF;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h00000000);
    check(rd & mask, exp);
  endtask
  task idle_pulse();
    idle_req <= 1'b1;
    @(posedge clk_i);
    idle_req <= 1'b0;
    @(posedge clk_i);
  endtask
  task wait_lp(input logic [1:0] s);
    while (lp !== s) @(posedge clk_i);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h0000000F, 32'h00000000);
    rd_chk(pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000188, 32'h00000000);
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000);
    xfer(1'b1, pwlc_pkg::PWLC_WD_CTRL_OFS, 32'h00000040);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h00000005);
    check(32'(sel.use_pll), 32'h00000000);
    rd = 32'h00000000;
    while (rd[0] !== 1'b1) xfer(1'b0, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000000);
    check(32'(sel.use_pll), 32'h00000001);
    check(32'(sel.ratio), 32'h00000005);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000180);
    check(32'(sel.cpu_clock_in_divide_select), 32'h00000003);
    rd_chk(pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000188, 32'h00000180);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000000);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h00000007);
    check(32'(sel.use_pll), 32'h00000000);
    rd = 32'h00000000;
    while (rd[0] !== 1'b1) xfer(1'b0, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000000);
    check(32'(sel.ratio), 32'h00000007);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h00000000);
    check({sel.use_pll, sel.pll_powered}, 32'h00000001);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000008);
    check({sel.use_pll, sel.pll_powered}, 32'h00000000);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_STATUS_OFS, 32'h00000000);
    xfer(1'b1, pwlc_pkg::PWLC_WD_CTRL_OFS, 32'h00000000);
    repeat (1100) @(posedge clk_i);
    xfer(1'b0, pwlc_pkg::PWLC_WD_COUNT_OFS, 32'h00000000);
    check(32'(rd[7:0] >= 8'h02), 32'h00000001);
    xfer(1'b1, pwlc_pkg::PWLC_WD_KEY_OFS, 32'(pwlc_pkg::PWLC_WD_KEY1));
    xfer(1'b1, pwlc_pkg::PWLC_WD_KEY_OFS, 32'(pwlc_pkg::PWLC_WD_KEY2));
    xfer(1'b0, pwlc_pkg::PWLC_WD_COUNT_OFS, 32'h00000000);
    check(32'(rd[7:0] < 8'h02), 32'h00000001);
    osc_en <= 1'b0;
    while (mclk !== 1'b1) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    check(32'(sel.use_limp), 32'h00000001);
    check(32'(mclk), 32'h00000000);
    rd_chk(pwlc_pkg::PWLC_SYS_STATUS_OFS, 32'h00000001, 32'h00000001);
    xfer(1'b0, pwlc_pkg::PWLC_WD_COUNT_OFS, 32'h00000000);
    cnt = rd;
    repeat (1100) @(posedge clk_i);
    rd_chk(pwlc_pkg::PWLC_WD_COUNT_OFS, 32'h000000FF, cnt & 32'h000000FF);
    osc_en <= 1'b1;
    repeat (20) @(posedge clk_i);
    xfer(1'b1, pwlc_pkg::PWLC_SYS_STATUS_OFS, 32'h00000001);
    rd_chk(pwlc_pkg::PWLC_SYS_STATUS_OFS, 32'h00000001, 32'h00000000);
    xfer(1'b1, pwlc_pkg::PWLC_WAKE_SEL_OFS, 32'h00000008);
    xfer(1'b1, pwlc_pkg::PWLC_LOW_POWER_OFS, 32'h00000011);
    idle_pulse();
    check({lp, cpu_en, osc_run}, 32'h00000009);
    pull_low <= 32'h00000008;
    repeat (2) @(posedge clk_i);
    pull_low <= 32'h00000000;
    repeat (10) @(posedge clk_i);
    check(32'(lp), 32'h00000002);
    pull_low <= 32'h00000008;
    wait_lp(2'h0);
    pull_low <= 32'h00000000;
    check(32'(cpu_en), 32'h00000001);
    xfer(1'b1, pwlc_pkg::PWLC_LOW_POWER_OFS, 32'h00000002);
    idle_pulse();
    repeat (40) @(posedge clk_i);
    check({lp, osc_run}, 32'h00000006);
    pull_low <= 32'h00000008;
    wait_lp(2'h0);
    pull_low <= 32'h00000000;
    check(32'(osc_run), 32'h00000001);
    xfer(1'b1, pwlc_pkg::PWLC_LOW_POWER_OFS, 32'h00000000);
    for (int k = 0; k < 2; k++) begin
      idle_pulse();
      check({lp, cpu_en}, 32'h00000003);
      if (k == 0) en_int <= 1'b1;
      else nmi <= 1'b1;
      wait_lp(2'h0);
      en_int <= 1'b0;
      nmi <= 1'b0;
      check(32'(cpu_en), 32'h00000001);
    end
    check(32'(wakes), 32'h00000004);
    xfer(1'b1, pwlc_pkg::PWLC_WD_CTRL_OFS, 32'h00000040);
    xfer(1'b1, pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h00000003);
    pin_rst <= 1'b1;
    repeat (2) @(posedge clk_i);
    pin_rst <= 1'b0;
    @(posedge clk_i);
    check({sel.ratio, sel.use_pll, wd_n, wd_int}, 32'h00000002);
    rd_chk(pwlc_pkg::PWLC_PLL_RATIO_OFS, 32'h0000000F, 32'h00000000);
    rd_chk(pwlc_pkg::PWLC_WD_CTRL_OFS, 32'h00000040, 32'h00000000);
    give_verdict();
  end
endmodule
bind pwlc_ctrl pwlc_ctrl_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .clk_sel_o(clk_sel_o),
  .cpu_clock_en_o(cpu_clock_en_o), .osc_run_o(osc_run_o), .missing_clock_reset_o(missing_clock_reset_o),
  .wake_o(wake_o), .lp_state_o(lp_state_o));
